// >>> verilog/sram_byte_write_masking.sv
// burst write port with per-lane write masking, read port and write buffer
// Behaviour
// [RULE_01] write opens at a K rise with select low; word 1 at K_N rise
// [RULE_02] 18-bit, both lane selects low: all 18 bits of the word written
// [RULE_03] 18-bit, select 0 guards bits 8..0, select 1 bits 17..9
// [RULE_04] 18-bit, both selects high: that word leaves the array unchanged
// [RULE_05] 36-bit, all four selects low: all 36 bits written
// [RULE_06] 36-bit, only select 0 low: bits 8..0 written, rest kept
// [RULE_07] 36-bit, only select 1 low: bits 17..9 written, rest kept
// [RULE_08] 36-bit, only select 2 low: bits 26..18 written, rest kept
// [RULE_09] 36-bit, only select 3 low: bits 35..27 written, rest kept
// [RULE_10] 36-bit, all selects high: no update for that word
// [RULE_11] selects evaluated separately for the K word and the K_N word
// [RULE_12] after reset both ports idle and read data undriven
// [RULE_13] synchronous inputs captured only on K and K_N rises
// [RULE_14] read data launched on C/C_N rises, or K/K_N in single clock mode
// [RULE_15] controller should park K equal K_N and C, C_N high when stopped; sram_ctl_model parks C, C_N low outside single clock mode
// [RULE_16] any other select mix applied lane by lane
`timescale 1ns/1ps

module burst_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_state_t;

	fifo_state_t s_r;
	fifo_state_t s_nxt;
	logic push;
	logic pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("fifo depth must be a power of two, at least 2");
	end

	assign in_ready = s_r.cnt != (AW + 1)'(DEPTH);
	assign out_valid = s_r.cnt != '0;
	assign out_data = s_r.mem[s_r.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		s_nxt = s_r;
		if (ce) begin
			if (push) begin
				s_nxt.mem[s_r.wp] = in_data;
				s_nxt.wp = s_r.wp + 1'b1;
			end
			if (pop) begin
				s_nxt.rp = s_r.rp + 1'b1;
			end
			s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // burst_fifo

module sram_byte_write_masking
	import sram_bw_pkg::*;
#(
	parameter int LANES = LANES_36
) (
	// clock, reset, enable
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	// input clock pair and output clock pair, sampled as levels
	input wire logic K,
	input wire logic K_N,
	input wire logic C,
	input wire logic C_N,
	// port selects and address
	input wire logic READ_PORT_SELECT_N,
	input wire logic WRITE_PORT_SELECT_N,
	input wire logic [ADDR_W-1:0] ADDR,
	// write data and byte lane selects
	input wire logic [WORD_W-1:0] D,
	input wire logic [MAX_LANES-1:0] BYTE_LANE_WRITE_SELECT_N,
	// read data
	output logic [WORD_W-1:0] Q,
	output logic Q_OE,
	// write buffer status and array back-pressure
	output logic WR_BUF_READY,
	input wire logic ARRAY_HOLD
);
	if (LANES != LANES_18 && LANES != LANES_36) begin : g_bad_lanes
		$error("LANES must be 2 or 4");
	end

	ctl_state_t s_r;
	ctl_state_t s_nxt;
	wr_burst_t push_data;
	wr_burst_t pop_data;
	logic push_valid;
	logic pop_valid;
	logic pop_ready;
	logic k_rise;
	logic kn_rise;
	logic opos_rise;
	logic oneg_rise;
	lane_sel_t sel_in;
	logic wr_go;
	logic [ADDR_W:0] wr_idx;
	lane_sel_t wr_sel;
	word_t wr_data;
	word_t wr_old;
	word_t wr_merged;

	// unused upper lanes of the 18-bit organisation never write
	assign sel_in = (LANES == LANES_18) ?
		{2'h3, BYTE_LANE_WRITE_SELECT_N[1:0]} : BYTE_LANE_WRITE_SELECT_N;

	assign k_rise = K & ~s_r.k_q; // [RULE_13]
	assign kn_rise = K_N & ~s_r.kn_q; // [RULE_13]
	// the strap picks which pair times the read launch
	assign opos_rise = s_r.single_clk ? k_rise : (C & ~s_r.c_q); // [RULE_14]
	assign oneg_rise = s_r.single_clk ? kn_rise : (C_N & ~s_r.cn_q); // [RULE_14]

	// the burst enters the buffer once its second word is in
	assign push_valid = CE & (s_r.wph == WR_NEG) & kn_rise; // [RULE_01]
	assign push_data.addr = ADDR;
	assign push_data.d0 = s_r.d0;
	assign push_data.d1 = D;
	assign push_data.s0 = s_r.s0;
	assign push_data.s1 = sel_in; // [RULE_11]

	burst_fifo #(
		.WIDTH($bits(wr_burst_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.resetn(RESETN),
		.ce(CE),
		.in_valid(push_valid),
		.in_ready(WR_BUF_READY),
		.in_data(push_data),
		.out_valid(pop_valid),
		.out_ready(pop_ready),
		.out_data(pop_data)
	);

	// each burst takes two array cycles, one per word
	assign wr_go = CE & pop_valid & ~ARRAY_HOLD;
	assign pop_ready = ~ARRAY_HOLD & s_r.half;
	assign wr_idx = {pop_data.addr, s_r.half};
	assign wr_sel = s_r.half ? pop_data.s1 : pop_data.s0; // [RULE_11]
	assign wr_data = s_r.half ? pop_data.d1 : pop_data.d0;
	assign wr_old = s_r.mem[wr_idx];

	for (genvar i = 0; i < MAX_LANES; i++) begin : g_lane
		// a low select writes its own lane only
		assign wr_merged[i*LANE_W +: LANE_W] = wr_sel[i] ? // [RULE_05] [RULE_06]
			wr_old[i*LANE_W +: LANE_W] : // [RULE_07] [RULE_08] [RULE_09]
			wr_data[i*LANE_W +: LANE_W]; // [RULE_02] [RULE_03] [RULE_16]
	end

	assign Q = s_r.q;
	assign Q_OE = s_r.q_oe;

	always_comb begin
		s_nxt = s_r;
		if (CE) begin
			s_nxt.k_q = K;
			s_nxt.kn_q = K_N;
			s_nxt.c_q = C;
			s_nxt.cn_q = C_N;
			// strap caught on the first enabled edge after release
			if (!s_r.strap_done) begin
				s_nxt.strap_done = 1'b1;
				s_nxt.single_clk = C & C_N;
			end
			unique case (s_r.wph)
				WR_IDLE: begin
					if (k_rise && !WRITE_PORT_SELECT_N) begin // [RULE_01]
						s_nxt.d0 = D;
						s_nxt.s0 = sel_in; // [RULE_11]
						s_nxt.wph = WR_NEG;
					end
				end
				WR_NEG: begin
					// a full buffer drops the burst; WR_BUF_READY warns
					if (kn_rise) begin
						s_nxt.wph = WR_IDLE;
					end
				end
			endcase
			if (wr_go) begin
				s_nxt.mem[wr_idx] = wr_merged; // [RULE_04] [RULE_10]
				s_nxt.half = ~s_r.half;
			end
			// reads see the array only, not bursts still buffered
			unique case (s_r.rph)
				RD_IDLE: begin
					if (k_rise && !READ_PORT_SELECT_N) begin
						s_nxt.rd_addr = ADDR;
						s_nxt.rph = RD_ARM;
					end
				end
				RD_ARM: begin
					if (k_rise) begin
						s_nxt.rph = RD_WAIT;
					end
				end
				RD_WAIT: begin
					if (opos_rise) begin // [RULE_14]
						s_nxt.q = s_r.mem[{s_r.rd_addr, 1'b0}];
						s_nxt.q_oe = 1'b1;
						s_nxt.rph = RD_SECOND;
					end
				end
				RD_SECOND: begin
					if (oneg_rise) begin // [RULE_14]
						s_nxt.q = s_r.mem[{s_r.rd_addr, 1'b1}];
						s_nxt.rph = RD_LAST;
					end
				end
				RD_LAST: begin
					if (opos_rise) begin
						s_nxt.q_oe = 1'b0;
						s_nxt.rph = RD_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_r <= '0; // [RULE_12]
			s_r.wph <= WR_IDLE;
			s_r.rph <= RD_IDLE;
			s_r.s0 <= SEL_NONE;
			s_r.q <= WORD_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// checks
	sequence s_start;
		k_rise && !WRITE_PORT_SELECT_N && s_r.wph == WR_IDLE && CE;
	endsequence
	sequence s_wait_neg;
		s_r.wph == WR_NEG;
	endsequence

	a_burst_start: assert property ( // [RULE_01]
		@(posedge CLK) disable iff (!RESETN)
		s_start |=> s_wait_neg ##0 (s_r.d0 == $past(D) &&
		s_r.s0 == $past(sel_in)))
		else $error("write start not captured on K rise");
	a_full_18: assert property ( // [RULE_02]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel[1:0] == 2'h0 |=>
		s_r.mem[$past(wr_idx)][17:0] == $past(wr_data[17:0]))
		else $error("full 18-bit write lost bits");
	a_lane_split: assert property ( // [RULE_03]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel[1:0] == 2'h2 |=>
		s_r.mem[$past(wr_idx)][8:0] == $past(wr_data[8:0]) &&
		s_r.mem[$past(wr_idx)][17:9] == $past(wr_old[17:9]))
		else $error("lane 0 write touched lane 1");
	a_none_18: assert property ( // [RULE_04]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel[1:0] == 2'h3 |=>
		s_r.mem[$past(wr_idx)][17:0] == $past(wr_old[17:0]))
		else $error("masked 18-bit word changed array");
	a_full_36: assert property ( // [RULE_05]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel == 4'h0 |=>
		s_r.mem[$past(wr_idx)] == $past(wr_data))
		else $error("full 36-bit write lost bits");
	a_lane0_only: assert property ( // [RULE_06]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel == 4'he |=>
		s_r.mem[$past(wr_idx)] == {$past(wr_old[35:9]), $past(wr_data[8:0])})
		else $error("lane 0 write wrong");
	a_lane1_only: assert property ( // [RULE_07]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel == 4'hd |=>
		s_r.mem[$past(wr_idx)] == {$past(wr_old[35:18]),
		$past(wr_data[17:9]), $past(wr_old[8:0])})
		else $error("lane 1 write wrong");
	a_lane2_only: assert property ( // [RULE_08]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel == 4'hb |=>
		s_r.mem[$past(wr_idx)] == {$past(wr_old[35:27]),
		$past(wr_data[26:18]), $past(wr_old[17:0])})
		else $error("lane 2 write wrong");
	a_lane3_only: assert property ( // [RULE_09]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel == 4'h7 |=>
		s_r.mem[$past(wr_idx)] == {$past(wr_data[35:27]), $past(wr_old[26:0])})
		else $error("lane 3 write wrong");
	a_none_36: assert property ( // [RULE_10]
		@(posedge CLK) disable iff (!RESETN)
		wr_go && wr_sel == SEL_NONE |=>
		s_r.mem[$past(wr_idx)] == $past(wr_old))
		else $error("masked 36-bit word changed array");
	// checked through the buffer, so a lost or swapped select shows up
	a_second_sel: assert property ( // [RULE_11]
		@(posedge CLK) disable iff (!RESETN)
		push_valid && WR_BUF_READY && !pop_valid |=>
		pop_data.s1 == $past(sel_in) && pop_data.s0 == $past(s_r.s0) &&
		pop_data.d1 == $past(D))
		else $error("second word selects not kept per word");
	a_reset_idle: assert property (@(posedge CLK) // [RULE_12]
		$rose(RESETN) |-> !Q_OE && s_r.wph == WR_IDLE && s_r.rph == RD_IDLE)
		else $error("ports not idle after reset");
	a_capture_edge: assert property ( // [RULE_13]
		@(posedge CLK) disable iff (!RESETN)
		$changed(s_r.d0) |-> $past(k_rise))
		else $error("write data captured off a K rise");
	a_launch_edge: assert property ( // [RULE_14]
		@(posedge CLK) disable iff (!RESETN)
		$changed(Q) |-> $past(opos_rise) || $past(oneg_rise))
		else $error("read data launched off an output clock rise");
endmodule // sram_byte_write_masking

// >>> verilog/sram_bw_pkg.sv
// package: constants and types for the byte-lane masked burst write port
package sram_bw_pkg;

	localparam int LANE_W = 9;
	localparam int MAX_LANES = 4;
	localparam int WORD_W = LANE_W * MAX_LANES;
	localparam int ADDR_W = 6;
	localparam int MEM_WORDS = 2 ** (ADDR_W + 1);
	localparam int FIFO_DEPTH = 16;
	localparam int LANES_18 = 2;
	localparam int LANES_36 = 4;
	localparam logic [MAX_LANES-1:0] SEL_NONE = 4'hf;
	localparam logic [WORD_W-1:0] WORD_RST = 36'h0;

	typedef logic [MAX_LANES-1:0] lane_sel_t;
	typedef logic [WORD_W-1:0] word_t;

	typedef enum logic {WR_IDLE, WR_NEG} wr_phase_t;
	typedef enum logic [2:0] {RD_IDLE, RD_ARM, RD_WAIT, RD_SECOND, RD_LAST}
		rd_phase_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		word_t d0;
		word_t d1;
		lane_sel_t s0;
		lane_sel_t s1;
	} wr_burst_t;

	typedef struct packed {
		logic k_q;
		logic kn_q;
		logic c_q;
		logic cn_q;
		logic strap_done;
		logic single_clk;
		wr_phase_t wph;
		word_t d0;
		lane_sel_t s0;
		rd_phase_t rph;
		logic [ADDR_W-1:0] rd_addr;
		word_t q;
		logic q_oe;
		logic half;
		logic [MEM_WORDS-1:0][WORD_W-1:0] mem;
	} ctl_state_t;

endpackage

// >>> test/sram_ctl_model.sv
// behavioural memory controller driving the write and read ports
`timescale 1ns/1ps

module sram_ctl_model
	import sram_bw_pkg::*;
(
	// clock
	input wire logic clk,
	// clock pairs, selects, address, data
	output logic k,
	output logic k_n,
	output logic c,
	output logic c_n,
	output logic rd_sel_n,
	output logic wr_sel_n,
	output logic [ADDR_W-1:0] addr,
	output word_t d,
	output lane_sel_t lane_sel_n,
	// read data seen from both organisations
	input wire word_t q_a,
	input wire logic q_oe_a,
	input wire word_t q_b
);
	initial begin
		k = 1'b0; // clocks parked equal when stopped
		k_n = 1'b0;
		c = 1'b0; // low, so the single clock strap stays off
		c_n = 1'b0;
		rd_sel_n = 1'b1;
		wr_sel_n = 1'b1;
		addr = 6'h00;
		d = 36'h0;
		lane_sel_n = 4'hf;
	end

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic burst(input logic [ADDR_W-1:0] a, input word_t w0, w1,
		input lane_sel_t s0, s1);
		step();
		k = 1'b1; // burst opens at a K rise with word 0
		wr_sel_n = 1'b0;
		d = w0;
		lane_sel_n = s0; // each word carries its own lanes
		step();
		k = 1'b0;
		k_n = 1'b1; // word 1 and address at the K_N rise
		wr_sel_n = 1'b1;
		addr = a;
		d = w1;
		lane_sel_n = s1;
		step();
		k_n = 1'b0;
		d = ~w1; // released lines must not keep showing the last word
		lane_sel_n = ~s1;
		addr = ~a;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output word_t a0, a1, b0,
		b1, output logic oe0, oe_end);
		step();
		k = 1'b1;
		rd_sel_n = 1'b0;
		addr = a;
		step();
		k = 1'b0;
		rd_sel_n = 1'b1;
		addr = ~a;
		step();
		k = 1'b1;
		step();
		k = 1'b0;
		c = 1'b1;
		step();
		c = 1'b0;
		step();
		a0 = q_a;
		b0 = q_b;
		oe0 = q_oe_a;
		c_n = 1'b1;
		step();
		c_n = 1'b0;
		step();
		a1 = q_a;
		b1 = q_b;
		c = 1'b1;
		step();
		c = 1'b0;
		repeat (2) step();
		oe_end = q_oe_a;
	endtask

	// both output clocks high through reset select single clock mode
	task automatic park(input logic v);
		c = v; // output clocks parked at level v when stopped
		c_n = v;
	endtask

	// single clock mode: K and K_N also time the read data
	task automatic rd1(input logic [ADDR_W-1:0] a, output word_t a0, a1,
		b0, b1, output logic oe0, oe_end);
		step();
		k = 1'b1;
		rd_sel_n = 1'b0;
		addr = a;
		step();
		k = 1'b0;
		rd_sel_n = 1'b1;
		addr = ~a;
		step();
		k = 1'b1;
		step();
		k = 1'b0;
		step();
		k = 1'b1;
		step();
		a0 = q_a;
		b0 = q_b;
		oe0 = q_oe_a;
		k = 1'b0;
		k_n = 1'b1;
		step();
		a1 = q_a;
		b1 = q_b;
		k_n = 1'b0;
		step();
		k = 1'b1;
		step();
		k = 1'b0;
		step();
		oe_end = q_oe_a;
	endtask
endmodule // sram_ctl_model

// >>> test/testbench.sv
// testbench: lane masked bursts in both organisations and buffer overflow
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module testbench
	import sram_bw_pkg::*;
;
	localparam word_t BASE = 36'h123456789;
	localparam word_t NEW0 = 36'hfedcba987;
	localparam word_t NEW1 = 36'h0f1e2d3c4;
	logic clk, resetn, ce, hold, k, k_n, c, c_n, rd_n, wr_n, oe36, rdy36;
	logic [ADDR_W-1:0] addr;
	word_t d, q36, q18;
	lane_sel_t sel_n;
	int n_fail = 0;
	int compares = 0;

	sram_ctl_model m (.clk(clk), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
		.rd_sel_n(rd_n), .wr_sel_n(wr_n), .addr(addr), .d(d),
		.lane_sel_n(sel_n), .q_a(q36), .q_oe_a(oe36), .q_b(q18));
	sram_byte_write_masking #(.LANES(LANES_36)) dut (.CLK(clk),
		.RESETN(resetn), .CE(ce), .K(k), .K_N(k_n), .C(c), .C_N(c_n),
		.READ_PORT_SELECT_N(rd_n), .WRITE_PORT_SELECT_N(wr_n), .ADDR(addr),
		.D(d), .BYTE_LANE_WRITE_SELECT_N(sel_n), .Q(q36), .Q_OE(oe36),
		.WR_BUF_READY(rdy36), .ARRAY_HOLD(hold));
	sram_byte_write_masking #(.LANES(LANES_18)) dut18 (.CLK(clk),
		.RESETN(resetn), .CE(ce), .K(k), .K_N(k_n), .C(c), .C_N(c_n),
		.READ_PORT_SELECT_N(rd_n), .WRITE_PORT_SELECT_N(wr_n), .ADDR(addr),
		.D(d), .BYTE_LANE_WRITE_SELECT_N(sel_n), .Q(q18), .Q_OE(),
		.WR_BUF_READY(), .ARRAY_HOLD(hold));

	function automatic word_t merge(word_t o, word_t n, lane_sel_t s);
		word_t r;
		r = o;
		for (int i = 0; i < LANES_36; i++) begin
			if (!s[i]) r[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
		end
		return r;
	endfunction

	task automatic close_out();
		$display("compares %0d, n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// seven select patterns, word 1 gets the inverse selects of word 0
	task automatic t_lanes();
		lane_sel_t pats [7];
		word_t b, e, a0, a1, b0, b1;
		logic oe0, oe1;
		pats = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'hf, 4'ha};
		for (int i = 0; i < 7; i++) begin
			b = BASE ^ 36'(i);
			m.burst(6'h28 + 6'(i), b, ~b, 4'h0, 4'h0);
			m.burst(6'h28 + 6'(i), NEW0, NEW1, pats[i], ~pats[i]);
			repeat (8) @(posedge clk);
			m.rd(6'h28 + 6'(i), a0, a1, b0, b1, oe0, oe1);
			e = merge(b, NEW0, pats[i]);
			`CHK("w0_36", e, a0)
			`CHK("w0_18", e[17:0], b0[17:0])
			e = merge(~b, NEW1, ~pats[i]);
			`CHK("w1_36", e, a1)
			`CHK("w1_18", e[17:0], b1[17:0])
			`CHK("oe_on", 1'b1, oe0)
			`CHK("oe_off", 1'b0, oe1)
		end
	endtask

	// stalled drain fills the buffer; a burst beyond it is dropped
	task automatic t_fill();
		word_t a0, a1, b0, b1;
		logic oe0, oe1;
		m.burst(6'h3e, BASE, NEW1, 4'h0, 4'h0);
		repeat (8) @(posedge clk);
		#1 hold = 1'b1;
		for (int i = 0; i < 16; i++) begin
			m.burst(6'(i), NEW0 ^ 36'(i), NEW1, 4'h0, 4'h0);
			if (i == 14) `CHK("rdy_15", 1'b1, rdy36)
		end
		`CHK("rdy_full", 1'b0, rdy36)
		m.burst(6'h3e, NEW0, NEW0, 4'h0, 4'h0);
		ce = 1'b0;
		hold = 1'b0;
		repeat (4) @(posedge clk);
		#1 `CHK("rdy_frozen", 1'b0, rdy36)
		ce = 1'b1;
		repeat (60) @(posedge clk);
		#1 `CHK("rdy_empty", 1'b1, rdy36)
		m.rd(6'h3e, a0, a1, b0, b1, oe0, oe1);
		`CHK("drop_w0", BASE, a0)
		`CHK("drop_w1", NEW1, a1)
		m.rd(6'h0f, a0, a1, b0, b1, oe0, oe1);
		`CHK("last_w0", NEW0 ^ 36'hf, a0)
	endtask

	// second reset with both output clocks high: K times the reads
	task automatic t_single();
		word_t a0, a1, b0, b1, e;
		logic oe0, oe1;
		m.park(1'b1);
		resetn = 1'b0;
		repeat (3) @(posedge clk);
		#1 resetn = 1'b1;
		m.burst(6'h15, NEW0, NEW1, 4'h5, 4'ha);
		repeat (8) @(posedge clk);
		m.rd1(6'h15, a0, a1, b0, b1, oe0, oe1);
		e = merge(WORD_RST, NEW0, 4'h5);
		`CHK("sc_w0_36", e, a0)
		`CHK("sc_w0_18", e[17:0], b0[17:0])
		e = merge(WORD_RST, NEW1, 4'ha);
		`CHK("sc_w1_36", e, a1)
		`CHK("sc_w1_18", e[17:0], b1[17:0])
		`CHK("sc_oe_on", 1'b1, oe0)
		`CHK("sc_oe_off", 1'b0, oe1)
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#(40 * 5000);
		n_fail++;
		close_out();
	end

	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		hold = 1'b0;
		repeat (10) @(posedge clk);
		#1 `CHK("rst_oe", 1'b0, oe36)
		`CHK("rst_q", 36'h0, q36)
		`CHK("rst_rdy", 1'b1, rdy36)
		resetn = 1'b1;
		repeat (2) @(posedge clk);
		t_lanes();
		t_fill();
		t_single();
		close_out();
	end
endmodule // testbench
